/* File: rtl/gem_cfg.svh */
// Constants of the six-pin GPIO block with edge events and pad multiplexing.
// Assumes it is included by bare name from the package and the top module.
`ifndef GEM_CFG_SVH
`define GEM_CFG_SVH

`define GEM_ADDR_W 5
`define GEM_DATA_W 16
`define GEM_REG_W 8
`define GEM_NPIN 6
`define GEM_NFN 4
`define GEM_FN_BASE 2
`define GEM_CFG_W 2

`define GEM_OFS_OUT 5'h00
`define GEM_OFS_DIR 5'h02
`define GEM_OFS_IN 5'h04
`define GEM_OFS_RISE_EN 5'h06
`define GEM_OFS_RISE_PEND 5'h08
`define GEM_OFS_RISE_ACK 5'h0a
`define GEM_OFS_FALL_EN 5'h0c
`define GEM_OFS_FALL_PEND 5'h0e
`define GEM_OFS_FALL_ACK 5'h10
`define GEM_OFS_CFG 5'h12

`define GEM_RST_OUT 8'h00
`define GEM_RST_DIR 8'h3f
`define GEM_RST_EN 8'h00
`define GEM_RST_CFG 2'h0
`define GEM_RST_PIN 6'h00
`define GEM_RDATA_ZERO 16'h0000
`define GEM_PAD8_ZERO 8'h00
`define GEM_PAD10_ZERO 10'h000
`define GEM_PAD14_ZERO 14'h0000
`define GEM_PIN_ZERO 2'h0

`define GEM_CFG_SPI_BIT 0
`define GEM_FN_CSN 3
`define GEM_FN_TDO 0

`endif

/* File: rtl/gem_pkg.sv */
// Types shared by the GPIO block and its surroundings.
// Assumes gem_cfg.svh is on the include path.
`include "gem_cfg.svh"

package gem_pkg;

  typedef struct packed {
    logic [`GEM_ADDR_W-1:0] addr;
    logic [`GEM_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } gem_bus_t;

  typedef struct packed {
    logic [`GEM_NFN-1:0] dout;
    logic [`GEM_NFN-1:0] oe;
  } gem_fn_drv_t;

  typedef enum logic [1:0] {
    GEM_MODE_GPIO = 2'b00,
    GEM_MODE_SPI = 2'b01,
    GEM_MODE_TEST = 2'b10
  } gem_mode_t;

endpackage

/* File: rtl/gem_top.sv */
// GPIO block: six pads, four of them shared, edge event flags, register port and pad mux.
// Assumes one clock, a synchronous reset, a master that never sees a wait,
// and an outside pad ring that resolves each pad from its output enable.
// The clock enable gates every register, the register port included.
//
// What this block does
// - Output register 0x00, bits 7:0, resets zero.
// - Direction register 0x02 resets 0x003F, one means input.
// - Read-only input register 0x04 shows pin levels.
// - Enabled rising edge sets rising pending bit.
// - Rising pending bits read at 0x08, sticky.
// - Write one at 0x0A clears rising pending.
// - Enabled falling edge sets falling pending bit.
// - Falling pending bits read at 0x0E, sticky.
// - Write one at 0x10 clears falling pending.
// - Config register 0x12, bits 1:0 writable only.
// - Config bit 0 puts SPI on pads two-five.
// - Test pin high routes test port, overriding config.
// - Pads zero and one are always GPIO.
// - After reset every pad is pulled-down GPIO input.
// - Test select input pulled down by default.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "gem_cfg.svh"

module gem_top
  import gem_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  input wire gem_bus_t I_BUS,
  output logic [`GEM_DATA_W-1:0] O_RDATA,
  input wire logic [`GEM_NPIN-1:0] I_PAD,
  output logic [`GEM_NPIN-1:0] O_PAD,
  output logic [`GEM_NPIN-1:0] O_PAD_OE,
  output logic [`GEM_NPIN-1:0] O_PAD_PD,
  input wire logic I_TEST_SELECT_PIN,
  output logic O_TEST_SELECT_PD,
  input wire gem_fn_drv_t I_SPI_DRV,
  output logic [`GEM_NFN-1:0] O_SPI_IN,
  input wire logic I_TEST_TDO,
  input wire logic I_TEST_TDO_OE,
  output logic [`GEM_NFN-2:0] O_TEST_IN,
  output logic O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  // Eight-bit registers keep bits 7:6 for read-back although only six pins exist.
  logic [`GEM_REG_W-1:0] out_q;
  logic [`GEM_REG_W-1:0] dir_q;
  logic [`GEM_REG_W-1:0] rise_en_q;
  logic [`GEM_REG_W-1:0] fall_en_q;
  logic [`GEM_CFG_W-1:0] cfg_q;
  logic [`GEM_NPIN-1:0] level_vec;
  logic [`GEM_NPIN-1:0] rise_vec;
  logic [`GEM_NPIN-1:0] fall_vec;
  logic [`GEM_DATA_W-1:0] rdata_d;
  logic wr_out;
  logic wr_dir;
  logic wr_rise_en;
  logic wr_fall_en;
  logic wr_rise_ack;
  logic wr_fall_ack;
  logic wr_cfg;
  gem_mode_t mode;

  // Addresses are compared in full, so an odd offset never aliases a register.
  assign wr_out = I_BUS.wr && (I_BUS.addr == `GEM_OFS_OUT);
  assign wr_dir = I_BUS.wr && (I_BUS.addr == `GEM_OFS_DIR);
  assign wr_rise_en = I_BUS.wr && (I_BUS.addr == `GEM_OFS_RISE_EN);
  assign wr_fall_en = I_BUS.wr && (I_BUS.addr == `GEM_OFS_FALL_EN);
  assign wr_rise_ack = I_BUS.wr && (I_BUS.addr == `GEM_OFS_RISE_ACK);
  assign wr_fall_ack = I_BUS.wr && (I_BUS.addr == `GEM_OFS_FALL_ACK);
  assign wr_cfg = I_BUS.wr && (I_BUS.addr == `GEM_OFS_CFG);

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      out_q <= `GEM_RST_OUT;
    end else if (I_CE && wr_out) begin
      out_q <= I_BUS.wdata[`GEM_REG_W-1:0];
    end
  end

  // Inputs after reset keep every pad undriven and pulled down.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      dir_q <= `GEM_RST_DIR;
    end else if (I_CE && wr_dir) begin
      dir_q <= I_BUS.wdata[`GEM_REG_W-1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rise_en_q <= `GEM_RST_EN;
    end else if (I_CE && wr_rise_en) begin
      rise_en_q <= I_BUS.wdata[`GEM_REG_W-1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      fall_en_q <= `GEM_RST_EN;
    end else if (I_CE && wr_fall_en) begin
      fall_en_q <= I_BUS.wdata[`GEM_REG_W-1:0];
    end
  end

  // Bit 1 is stored and read back but steers nothing.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cfg_q <= `GEM_RST_CFG;
    end else if (I_CE && wr_cfg) begin
      cfg_q <= I_BUS.wdata[`GEM_CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, answered in the cycle after the strobe.

  // Clear registers and unmapped offsets fall to the default and read zero.
  always_comb begin
    rdata_d = `GEM_RDATA_ZERO;
    case (I_BUS.addr)
      `GEM_OFS_OUT: rdata_d = {`GEM_PAD8_ZERO, out_q};
      `GEM_OFS_DIR: rdata_d = {`GEM_PAD8_ZERO, dir_q};
      `GEM_OFS_IN: rdata_d = {`GEM_PAD10_ZERO, level_vec};
      `GEM_OFS_RISE_EN: rdata_d = {`GEM_PAD8_ZERO, rise_en_q};
      `GEM_OFS_RISE_PEND: rdata_d = {`GEM_PAD10_ZERO, rise_vec};
      `GEM_OFS_FALL_EN: rdata_d = {`GEM_PAD8_ZERO, fall_en_q};
      `GEM_OFS_FALL_PEND: rdata_d = {`GEM_PAD10_ZERO, fall_vec};
      `GEM_OFS_CFG: rdata_d = {`GEM_PAD14_ZERO, cfg_q};
      default: rdata_d = `GEM_RDATA_ZERO;
    endcase
  end

  // Read data is zero outside the answer cycle so stale values never linger.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_RDATA <= `GEM_RDATA_ZERO;
    end else if (I_CE) begin
      O_RDATA <= I_BUS.rd ? rdata_d : `GEM_RDATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad function selection.

  // The select pin is taken as a static strap and is not synchronised; a change
  // while the block runs may upset the shared pads for one cycle.
  always_comb begin
    mode = GEM_MODE_GPIO;
    if (I_TEST_SELECT_PIN) begin
      mode = GEM_MODE_TEST;
    end else if (cfg_q[`GEM_CFG_SPI_BIT]) begin
      mode = GEM_MODE_SPI;
    end
  end

  // The select pin is only an input here; its pull-down is held on always.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_TEST_SELECT_PD <= 1'b1;
    end else if (I_CE) begin
      O_TEST_SELECT_PD <= 1'b1;
    end
  end

  // The request trails the pending bits by a cycle so that it leaves a flop.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_IRQ <= 1'b0;
    end else if (I_CE) begin
      O_IRQ <= (|rise_vec) || (|fall_vec);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pad logic: synchroniser, edge flags, output mux and function inputs.

  genvar gi;
  generate
    for (gi = 0; gi < `GEM_NPIN; gi = gi + 1) begin : g_pad
      logic meta_q;
      logic sync_q;
      logic prev_q;
      logic rise_q;
      logic fall_q;
      logic pad_q;
      logic oe_q;
      logic pd_q;
      logic drv_d;
      logic oe_d;
      logic rise_hit;
      logic fall_hit;

      // The first stage feeds only the second one.
      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (I_CE) begin
          meta_q <= I_PAD[gi];
          sync_q <= meta_q;
        end
      end

      // The previous sample resets to the pulled-down idle level, so a pad held low shows no edge after reset.
      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          prev_q <= 1'b0;
        end else if (I_CE) begin
          prev_q <= sync_q;
        end
      end

      assign level_vec[gi] = sync_q;
      assign rise_hit = rise_en_q[gi] && sync_q && !prev_q;
      assign fall_hit = fall_en_q[gi] && !sync_q && prev_q;

      // A new edge in the clearing cycle wins so no event is lost.
      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          rise_q <= 1'b0;
        end else if (I_CE) begin
          if (rise_hit) begin
            rise_q <= 1'b1;
          end else if (wr_rise_ack && I_BUS.wdata[gi]) begin
            rise_q <= 1'b0;
          end
        end
      end

      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          fall_q <= 1'b0;
        end else if (I_CE) begin
          if (fall_hit) begin
            fall_q <= 1'b1;
          end else if (wr_fall_ack && I_BUS.wdata[gi]) begin
            fall_q <= 1'b0;
          end
        end
      end

      assign rise_vec[gi] = rise_q;
      assign fall_vec[gi] = fall_q;

      // Pads zero and one stay on GPIO whatever the mode.
      if (gi < `GEM_FN_BASE) begin : g_fixed
        always_comb begin
          drv_d = out_q[gi];
          oe_d = !dir_q[gi];
        end
      end else begin : g_shared
        localparam int FN = gi - `GEM_FN_BASE;
        logic fn_in_q;

        always_comb begin
          drv_d = 1'b0;
          oe_d = 1'b0;
          case (mode)
            GEM_MODE_GPIO: begin
              drv_d = out_q[gi];
              oe_d = !dir_q[gi];
            end
            GEM_MODE_SPI: begin
              drv_d = I_SPI_DRV.dout[FN];
              oe_d = I_SPI_DRV.oe[FN];
            end
            // Only the data-out pad drives in test mode; the other three listen.
            GEM_MODE_TEST: begin
              if (FN == `GEM_FN_TDO) begin
                drv_d = I_TEST_TDO;
                oe_d = I_TEST_TDO_OE;
              end
            end
            default: begin
              drv_d = 1'b0;
              oe_d = 1'b0;
            end
          endcase
        end

        // An unselected chip select reads idle high so the SPI stays quiet.
        always_ff @(posedge I_CLK) begin
          if (I_SRST) begin
            fn_in_q <= (FN == `GEM_FN_CSN);
          end else if (I_CE) begin
            if (mode == GEM_MODE_SPI) begin
              fn_in_q <= I_PAD[gi];
            end else begin
              fn_in_q <= (FN == `GEM_FN_CSN);
            end
          end
        end
        assign O_SPI_IN[FN] = fn_in_q;

        // The data-out pad has no path toward the test port.
        if (FN != `GEM_FN_TDO) begin : g_test_in
          logic test_in_q;
          always_ff @(posedge I_CLK) begin
            if (I_SRST) begin
              test_in_q <= 1'b0;
            end else if (I_CE) begin
              test_in_q <= (mode == GEM_MODE_TEST) && I_PAD[gi];
            end
          end
          assign O_TEST_IN[FN-1] = test_in_q;
        end
      end

      // Drive and enable are registered so that every pad output leaves a flop.
      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          pad_q <= 1'b0;
          oe_q <= 1'b0;
        end else if (I_CE) begin
          pad_q <= drv_d;
          oe_q <= oe_d;
        end
      end

      // Pull-down follows the drive: on whenever the pad is not driven.
      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          pd_q <= 1'b1;
        end else if (I_CE) begin
          pd_q <= !oe_d;
        end
      end

      assign O_PAD[gi] = pad_q;
      assign O_PAD_OE[gi] = oe_q;
      assign O_PAD_PD[gi] = pd_q;
    end
  endgenerate

endmodule

/* File: tb/gem_top_monitor.sv */
// Port-level checker for the GPIO block.
// Assumes it is bound into gem_top and that the clock enable stays high.
`timescale 1ns/10ps
`include "gem_cfg.svh"
module gem_top_monitor
  import gem_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire gem_bus_t I_BUS,
  input wire logic [15:0] O_RDATA,
  input wire logic [5:0] I_PAD,
  input wire logic [5:0] O_PAD_OE,
  input wire logic [5:0] O_PAD_PD,
  input wire logic I_TEST_SELECT_PIN,
  input wire logic O_TEST_SELECT_PD,
  input wire logic I_TEST_TDO_OE,
  input wire logic [2:0] O_TEST_IN,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  property p_pd; O_PAD_PD == ~O_PAD_OE; endproperty
  a_pd: assert property (p_pd) else $error("pull-down on driven pad");
  property p_tpd; O_TEST_SELECT_PD; endproperty
  a_tpd: assert property (p_tpd) else $error("test pin pull-down off");
  property p_idle; !$past(I_BUS.rd) |-> O_RDATA == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_hi; $past(I_BUS.rd) |-> O_RDATA[15:8] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_wo;
    $past(I_BUS.rd) && ($past(I_BUS.addr) == 5'h0a || $past(I_BUS.addr) == 5'h10)
      |-> O_RDATA == 16'h0000;
  endproperty
  a_wo: assert property (p_wo) else $error("clear register readable");
  property p_tdo;
    $past(I_TEST_SELECT_PIN) && !$past(I_SRST) |-> O_PAD_OE[2] == $past(I_TEST_TDO_OE);
  endproperty
  a_tdo: assert property (p_tdo) else $error("pad two not test output");
  property p_tin; !$past(I_TEST_SELECT_PIN) |-> O_TEST_IN == 3'h0; endproperty
  a_tin: assert property (p_tin) else $error("test inputs outside test");
  // Pending needs a synchronised pad change, so the request never rises on its own.
  property p_rise;
    $rose(O_IRQ) |-> $past(I_PAD, 4) != $past(I_PAD, 5) || $past(I_PAD, 3) != $past(I_PAD, 4);
  endproperty
  a_rise: assert property (p_rise) else $error("request without edge");
  property p_fall;
    $fell(O_IRQ) |-> $past(I_BUS.wr, 2) &&
      ($past(I_BUS.addr, 2) == 5'h0a || $past(I_BUS.addr, 2) == 5'h10);
  endproperty
  a_fall: assert property (p_fall) else $error("request dropped unasked");
  c_rise: cover property ($rose(O_IRQ));
  c_fall: cover property ($fell(O_IRQ));
  c_test: cover property ($past(I_TEST_SELECT_PIN) && O_PAD_OE[2]);
endmodule
bind gem_top gem_top_monitor u_mon (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_BUS(I_BUS),
  .O_RDATA(O_RDATA), .I_PAD(I_PAD), .O_PAD_OE(O_PAD_OE), .O_PAD_PD(O_PAD_PD),
  .I_TEST_SELECT_PIN(I_TEST_SELECT_PIN), .O_TEST_SELECT_PD(O_TEST_SELECT_PD),
  .I_TEST_TDO_OE(I_TEST_TDO_OE), .O_TEST_IN(O_TEST_IN), .O_IRQ(O_IRQ));

/* File: tb/gem_pad_model.sv */
// Outside circuitry on the six pads: optional drivers plus pull-downs.
// Assumes the block's own drive wins wherever its enable is high.
`timescale 1ns/10ps
module gem_pad_model (
  input wire logic [5:0] i_drv,
  input wire logic [5:0] i_oe,
  input wire logic [5:0] i_ext_val,
  input wire logic [5:0] i_ext_en,
  output logic [5:0] o_lvl
);
  // A released pad with no outside driver enabled falls to the pull-down level, never its last value.
  assign o_lvl = (i_oe & i_drv) | (~i_oe & i_ext_en & i_ext_val);
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench: registers, edge events and pad multiplexing.
// Assumes the pad model closes the loop from pad outputs to pad inputs.
`timescale 1ns/10ps
module tb_top
  import gem_pkg::*;
;
  logic clk = 0, srst = 1, tsel = 0, tdo = 0, tdo_oe = 0, irq, tpd;
  gem_bus_t bus = '0;
  gem_fn_drv_t spi = '0;
  logic [5:0] ext_v = 0, ext_e = 0, pad_i, pad_o, pad_oe, pad_pd, old, nw, re, fe, m;
  logic [15:0] rdata;
  logic [3:0] spi_in;
  logic [2:0] test_in;
  logic [31:0] rnd = 32'd67981;
  logic [4:0] wa [5] = '{5'h00, 5'h02, 5'h06, 5'h0c, 5'h12};
  int err_count = 0, check_count = 0, cyc = 0;
  always #25 clk = ~clk;
  gem_top dut (.I_CLK(clk), .I_SRST(srst), .I_CE(1'b1), .I_BUS(bus), .O_RDATA(rdata),
    .I_PAD(pad_i), .O_PAD(pad_o), .O_PAD_OE(pad_oe), .O_PAD_PD(pad_pd),
    .I_TEST_SELECT_PIN(tsel), .O_TEST_SELECT_PD(tpd), .I_SPI_DRV(spi), .O_SPI_IN(spi_in),
    .I_TEST_TDO(tdo), .I_TEST_TDO_OE(tdo_oe), .O_TEST_IN(test_in), .O_IRQ(irq));
  gem_pad_model u_pads (.i_drv(pad_o), .i_oe(pad_oe), .i_ext_val(ext_v), .i_ext_en(ext_e),
    .o_lvl(pad_i));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] wmask(input logic [4:0] a);
    case (a)
      5'h00, 5'h02, 5'h06, 5'h0c: return 16'h00ff;
      5'h12: return 16'h0003;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk("read data", e, rdata);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 22; a += 2) rchk(a[4:0], (a == 2) ? 16'h003f : 16'h0000);
    for (int i = 0; i < 5; i++) begin
      rnd = nxt(rnd);
      wr(wa[i], rnd[15:0]);
      rchk(wa[i], rnd[15:0] & wmask(wa[i]));
    end
    wr(5'h12, 16'h0000);
    wr(5'h02, 16'h003f);
    ext_e <= 6'h3f;
    wr(5'h06, 16'h003f);
    wr(5'h0c, 16'h0015);
    wr(5'h04, 16'h00ff);
    wr(5'h0a, 16'h00ff);
    wr(5'h10, 16'h00ff);
    rchk(5'h04, 16'h0000);
    rchk(5'h08, 16'h0000);
    rchk(5'h0e, 16'h0000);
    old = 0;
    re = 0;
    fe = 0;
    for (int i = 0; i < 6; i++) begin
      rnd = nxt(rnd);
      nw = (i == 0) ? 6'h3f : rnd[5:0];
      @(posedge clk) ext_v <= nw;
      repeat (5) @(posedge clk);
      re |= nw & ~old;
      fe |= old & ~nw & 6'h15;
      old = nw;
      rchk(5'h04, {10'h000, nw});
      rchk(5'h08, {10'h000, re});
      rchk(5'h0e, {10'h000, fe});
      chk("irq", {15'h0, |(re | fe)}, {15'h0, irq});
    end
    rnd = nxt(rnd);
    m = rnd[5:0];
    wr(5'h0a, {10'h000, m});
    wr(5'h10, {10'h000, ~m});
    rchk(5'h08, {10'h000, re & ~m});
    rchk(5'h0e, {10'h000, fe & m});
    wr(5'h0a, 16'h00ff);
    wr(5'h10, 16'h00ff);
    wr(5'h06, 16'h0000);
    wr(5'h0c, 16'h0000);
    chk("irq", 16'h0000, {15'h0, irq});
    wr(5'h00, rnd[31:16]);
    wr(5'h02, 16'h0000);
    repeat (3) @(posedge clk);
    chk("pad drive", {10'h000, rnd[21:16]}, {10'h000, pad_o});
    chk("pad enable", 16'h003f, {10'h000, pad_oe});
    rchk(5'h04, {10'h000, rnd[21:16]});
    chk("spi idle", 16'h0008, {12'h000, spi_in});
    @(posedge clk) spi <= '{dout: rnd[3:0], oe: rnd[7:4]};
    wr(5'h12, 16'h0001);
    repeat (3) @(posedge clk);
    chk("spi enable", {12'h000, spi.oe}, {12'h000, pad_oe[5:2]});
    chk("spi drive", {12'h000, spi.dout & spi.oe}, {12'h000, pad_o[5:2] & spi.oe});
    chk("gpio pads", {14'h0, rnd[17:16]}, {14'h0, pad_o[1:0]});
    chk("spi in", {12'h0, spi.dout & spi.oe | ~spi.oe & old[5:2]}, {12'h0, spi_in});
    wr(5'h02, 16'h003c);
    tdo <= 1'b1;
    tdo_oe <= 1'b1;
    tsel <= 1'b1;
    repeat (4) @(posedge clk);
    chk("test enable", 16'h0001, {12'h000, pad_oe[5:2]});
    chk("test drive", 16'h0001, {15'h0, pad_o[2]});
    chk("test in", {13'h0, old[5:3]}, {13'h0, test_in});
    chk("gpio enable", 16'h0003, {14'h0, pad_oe[1:0]});
    chk("gpio drive", {14'h0, rnd[17:16]}, {14'h0, pad_o[1:0]});
    tsel <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset enable", 16'h0000, {10'h000, pad_oe});
    chk("reset pull", 16'h003f, {10'h000, pad_pd});
    chk("reset spi in", 16'h0008, {12'h000, spi_in});
    rchk(5'h02, 16'h003f);
    rchk(5'h12, 16'h0000);
    rchk(5'h08, 16'h0000);
    conclude();
  end
endmodule
